// ==== shared/fmd_pkg.sv ====
// Package with field layout, codes and reset values of the configuration words
package fmd_pkg;

  // ==========================================================================
  // Message framing
  // ==========================================================================
  localparam int unsigned MSG_W = 32;             // Width of one message word
  localparam int unsigned ACCESS_BIT = 31;        // Read (0) or write (1)
  localparam int unsigned ID_HI = 30;             // Identifier field top bit
  localparam int unsigned ID_LO = 26;             // Identifier field low bit
  localparam logic [4:0] ID_MODE_MASK = 5'h07;    // Mode and fault mask word
  localparam logic [4:0] ID_DIAG_CFG = 5'h08;     // Short-to-battery config word
  localparam logic [4:0] ID_DIAG_READ = 5'h09;    // Diagnostic read message

  // ==========================================================================
  // Mode and fault mask word fields
  // ==========================================================================
  localparam int unsigned NUM_CH = 4;             // Channels served
  localparam int unsigned MODE_CH0_BIT = 23;      // Channel 0 control mode
  localparam int unsigned MASK_CH0_BIT = 19;      // Channel 0 fault mask
  localparam int unsigned RST_PIN_MASK_BIT = 15;  // Gate for low enable pin
  localparam int unsigned EN_PIN_MASK_BIT = 14;   // Gate for low reset pin
  localparam int unsigned TMR_HI = 13;            // Diagnostic timer field top
  localparam int unsigned TMR_LO = 12;            // Diagnostic timer field low
  localparam int unsigned AZ_OFF_BIT = 11;        // Auto-zero off bit
  localparam logic [31:0] MODE_WR_MASK = 32'h00fff800; // Implemented bits
  localparam logic [31:0] MODE_RESET = 32'h00000000;   // Reset value

  // ==========================================================================
  // Diagnostic timer pre-divider values
  // ==========================================================================
  localparam int unsigned PREDIV_W = 9;
  localparam logic [8:0] PREDIV_CODE0 = 9'h080;   // 128
  localparam logic [8:0] PREDIV_CODE12 = 9'h0c0;  // 192
  localparam logic [8:0] PREDIV_CODE3 = 9'h100;   // 256

  // ==========================================================================
  // Short-to-battery word fields
  // ==========================================================================
  localparam int unsigned DIAG_W = 24;            // Implemented low bits
  localparam int unsigned CH_STRIDE = 6;          // Bits per channel
  localparam int unsigned THR_OFS = 4;            // Threshold offset in slice
  localparam int unsigned RETRY_OFS = 0;          // Retry offset in slice
  localparam int unsigned RETRY_W = 4;            // Retry field width
  localparam int unsigned RETRY_SCALE = 4;        // PWM periods per step
  localparam int unsigned RETRY_CNT_W = 6;        // Holds up to 60 periods
  localparam logic [23:0] DIAG_RESET = 24'hffffff; // All ones after reset

endpackage : fmd_pkg

// ==== core/fmd_retry_timer.sv ====
// Per-channel short-to-battery retry timer counted in PWM periods
`timescale 1ns/1ps
`default_nettype none

module fmd_retry_timer
  import fmd_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_pwm_tick,
  input wire logic i_short_battery_fault,
  input wire logic [RETRY_W-1:0] i_retry_code,
  output logic o_retry,
  output logic o_waiting
);

  // ==========================================================================
  // State
  // ==========================================================================
  logic [RETRY_CNT_W-1:0] cnt_q, cnt_d;   // Remaining PWM periods
  logic wait_q, wait_d;                   // Wait in progress
  logic retry_q, retry_d;                 // Retry strobe

  // Zero code means one period, else four periods per step
  function automatic logic [RETRY_CNT_W-1:0] wait_len(input logic [RETRY_W-1:0] code);
    logic [RETRY_CNT_W-1:0] len;
    len = RETRY_CNT_W'(code) * RETRY_CNT_W'(RETRY_SCALE);
    if (code == '0) begin
      len = RETRY_CNT_W'(1);
    end
    return len;
  endfunction : wait_len

  // ==========================================================================
  // Next state
  // ==========================================================================
  // Fault starts a wait; a new fault while waiting restarts it
  always_comb begin
    cnt_d = cnt_q;
    wait_d = wait_q;
    retry_d = 1'b0;
    if (i_short_battery_fault) begin
      cnt_d = wait_len(i_retry_code);
      wait_d = 1'b1;
    end else if (wait_q && i_pwm_tick) begin
      if (cnt_q <= RETRY_CNT_W'(1)) begin
        // Last period done, fire retry
        wait_d = 1'b0;
        retry_d = 1'b1;
        cnt_d = '0;
      end else begin
        cnt_d = cnt_q - RETRY_CNT_W'(1);
      end
    end
  end

  // Registers only
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      cnt_q <= '0;
      wait_q <= 1'b0;
      retry_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      wait_q <= wait_d;
      retry_q <= retry_d;
    end
  end

  assign o_retry = retry_q;
  assign o_waiting = wait_q;

endmodule : fmd_retry_timer

`default_nettype wire

// ==== core/fmd_config_regs.sv ====
// Mode, fault mask and short-to-battery configuration words with message decode
`timescale 1ns/1ps
`default_nettype none

// Function
// - Identifier 07 selects mode and mask word
// - Mode bit: 0 current control, 1 on/off
// - Mask bit 1 lets channel fault through
// - Bit 15 gates low enable pin fault
// - Bit 14 gates low reset pin fault
// - Enable fall latches; cleared high plus read
// - Timer code selects divide 128/192/192/256
// - Bit 11 set stops auto-zero
// - Identifier 08 selects short-to-battery word
// - Two-bit threshold code per channel
// - Retry wait is four periods per step
// - Zero retry step waits one period
// - Short-to-battery word resets to all ones
module fmd_config_regs
  import fmd_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_msg_valid,
  input wire logic [MSG_W-1:0] i_msg_data,
  input wire logic i_enable_pin,
  input wire logic i_reset_b_pin,
  input wire logic [NUM_CH-1:0] i_chan_fault,
  input wire logic [NUM_CH-1:0] i_short_battery_fault,
  input wire logic i_pwm_tick,
  output logic o_resp_valid,
  output logic [MSG_W-1:0] o_resp_data,
  output logic o_fault,
  output logic o_enable_fault_latch,
  output logic [NUM_CH-1:0] o_channel_control_mode,
  output logic [PREDIV_W-1:0] o_diag_prediv,
  output logic o_auto_zero_off,
  output logic [2*NUM_CH-1:0] o_short_battery_threshold,
  output logic [NUM_CH-1:0] o_short_battery_retry,
  output logic [NUM_CH-1:0] o_short_battery_waiting
);

  // ==========================================================================
  // Helper functions
  // ==========================================================================
  // Channel slice base in the short-to-battery word; channel 0 sits on top
  function automatic int unsigned ch_base(input int unsigned ch);
    return (NUM_CH - 1 - ch) * CH_STRIDE;
  endfunction : ch_base

  // Threshold code of one channel
  function automatic logic [1:0] thr_code(input logic [DIAG_W-1:0] w,
                                          input int unsigned ch);
    return w[ch_base(ch) + THR_OFS +: 2];
  endfunction : thr_code

  // Retry code of one channel
  function automatic logic [RETRY_W-1:0] retry_code(input logic [DIAG_W-1:0] w,
                                                    input int unsigned ch);
    return w[ch_base(ch) + RETRY_OFS +: RETRY_W];
  endfunction : retry_code

  // Pre-divider from the timer code
  function automatic logic [PREDIV_W-1:0] prediv(input logic [1:0] code);
    logic [PREDIV_W-1:0] p;
    p = PREDIV_CODE12;
    if (code == 2'h0) begin
      p = PREDIV_CODE0;
    end else if (code == 2'h3) begin
      p = PREDIV_CODE3;
    end
    return p;
  endfunction : prediv

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic en_meta_q, en_sync_q, en_prev_q;   // Enable pin chain
  logic rb_meta_q, rb_sync_q;              // Reset pin chain

  // Pins are asynchronous; only the second stage and the enable edge stage after it are ever looked at
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      en_meta_q <= 1'b1;
      en_sync_q <= 1'b1;
      en_prev_q <= 1'b1;
      rb_meta_q <= 1'b1;
      rb_sync_q <= 1'b1;
    end else begin
      en_meta_q <= i_enable_pin;
      en_sync_q <= en_meta_q;
      en_prev_q <= en_sync_q;
      rb_meta_q <= i_reset_b_pin;
      rb_sync_q <= rb_meta_q;
    end
  end

  // ==========================================================================
  // Message decode
  // ==========================================================================
  logic [4:0] message_identifier; // Identifier field of incoming word
  logic msg_write;           // Access type bit
  logic hit_mode;            // Addresses mode and mask word
  logic hit_diag;            // Addresses short-to-battery word
  logic hit_read;            // Diagnostic read arrived

  always_comb begin
    message_identifier = i_msg_data[ID_HI:ID_LO];
    // top bit picks write over read
    msg_write = i_msg_data[ACCESS_BIT];
    hit_mode = 1'b0;
    hit_diag = 1'b0;
    hit_read = 1'b0;
    if (!i_msg_valid) begin
      // Idle, nothing addressed
      hit_mode = 1'b0;
    end else if (message_identifier == ID_MODE_MASK) begin
      hit_mode = 1'b1;
    end else if (message_identifier == ID_DIAG_CFG) begin
      hit_diag = 1'b1;
    end else if (message_identifier == ID_DIAG_READ) begin
      // Used only to release the enable latch
      hit_read = 1'b1;
    end
  end

  // ==========================================================================
  // Configuration words
  // ==========================================================================
  logic [MSG_W-1:0] mode_q, mode_d;        // Mode and fault mask word
  logic [DIAG_W-1:0] diag_q, diag_d;       // Short-to-battery word

  // Writes store only implemented bits so unused ones stay zero
  always_comb begin
    mode_d = mode_q;
    diag_d = diag_q;
    if (hit_mode && msg_write) begin
      mode_d = i_msg_data & MODE_WR_MASK;
    end
    if (hit_diag && msg_write) begin
      diag_d = i_msg_data[DIAG_W-1:0];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      mode_q <= MODE_RESET;
      // threshold and retry fields all ones
      diag_q <= DIAG_RESET;
    end else begin
      mode_q <= mode_d;
      diag_q <= diag_d;
    end
  end

  // ==========================================================================
  // Response word
  // ==========================================================================
  logic resp_valid_q, resp_valid_d;        // Answer strobe
  logic [MSG_W-1:0] resp_q, resp_d;        // Answer word

  // Reads and writes both answer; a write echoes the value just stored
  always_comb begin
    resp_valid_d = 1'b0;
    resp_d = resp_q;
    if (hit_mode) begin
      // top bit zero, id echoed, unused zero
      resp_valid_d = 1'b1;
      resp_d = mode_d;
      resp_d[ID_HI:ID_LO] = ID_MODE_MASK;
      resp_d[ACCESS_BIT] = 1'b0;
    end else if (hit_diag) begin
      // same layout for the diagnostic word
      resp_valid_d = 1'b1;
      resp_d = '0;
      resp_d[DIAG_W-1:0] = diag_d;
      resp_d[ID_HI:ID_LO] = ID_DIAG_CFG;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      resp_valid_q <= 1'b0;
      resp_q <= '0;
    end else begin
      resp_valid_q <= resp_valid_d;
      resp_q <= resp_d;
    end
  end

  // ==========================================================================
  // Enable fault latch and fault output
  // ==========================================================================
  logic en_latch_q, en_latch_d;            // Enable pin fault latch
  logic fault_q, fault_d;                  // Fault pin level
  logic en_fall;                           // Enable high to low seen
  logic [NUM_CH-1:0] mode_bits;            // Per-channel mode
  logic [NUM_CH-1:0] mask_bits;            // Per-channel mask

  always_comb begin
    en_fall = en_prev_q && !en_sync_q;
    for (int i = 0; i < NUM_CH; i++) begin
      mode_bits[i] = mode_q[MODE_CH0_BIT - i];
      mask_bits[i] = mode_q[MASK_CH0_BIT - i];
    end
    en_latch_d = en_latch_q;
    // clear needs pin high and a read
    if (hit_read && en_sync_q) begin
      en_latch_d = 1'b0;
    end
    // a new fall wins over the clear
    if (en_fall) begin
      en_latch_d = 1'b1;
    end
    fault_d = |(i_chan_fault & mask_bits);
    // enable pin fault gated by bit 15
    if (mode_q[RST_PIN_MASK_BIT] && (en_latch_q || !en_sync_q)) begin
      fault_d = 1'b1;
    end
    // reset pin low gated by bit 14
    if (mode_q[EN_PIN_MASK_BIT] && !rb_sync_q) begin
      fault_d = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      en_latch_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      en_latch_q <= en_latch_d;
      fault_q <= fault_d;
    end
  end

  // ==========================================================================
  // Registered control outputs
  // ==========================================================================
  logic [NUM_CH-1:0] cmode_q, cmode_d;         // Channel control mode
  logic [PREDIV_W-1:0] prediv_q, prediv_d;     // Diagnostic pre-divider
  logic az_off_q, az_off_d;                    // Auto-zero stopped
  logic [2*NUM_CH-1:0] thr_q, thr_d;           // Threshold codes, ch0 low

  always_comb begin
    cmode_d = mode_bits;
    prediv_d = prediv(mode_q[TMR_HI:TMR_LO]);
    az_off_d = mode_q[AZ_OFF_BIT];
    for (int i = 0; i < NUM_CH; i++) begin
      thr_d[2*i +: 2] = thr_code(diag_q, i);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      cmode_q <= '0;
      prediv_q <= PREDIV_CODE0;
      az_off_q <= 1'b0;
      thr_q <= '1;
    end else begin
      cmode_q <= cmode_d;
      prediv_q <= prediv_d;
      az_off_q <= az_off_d;
      thr_q <= thr_d;
    end
  end

  // ==========================================================================
  // Retry timers
  // ==========================================================================
  // Timers read the live word, so a rewrite affects the next fault only
  for (genvar g = 0; g < NUM_CH; g++) begin : g_retry
    fmd_retry_timer u_timer (
      .i_sys_clk(i_sys_clk),
      .i_rst_b(i_rst_b),
      .i_pwm_tick(i_pwm_tick),
      .i_short_battery_fault(i_short_battery_fault[g]),
      .i_retry_code(retry_code(diag_q, g)),
      .o_retry(o_short_battery_retry[g]),
      .o_waiting(o_short_battery_waiting[g])
    );
  end

  // ==========================================================================
  // Output wiring, all from flip-flops
  // ==========================================================================
  assign o_resp_valid = resp_valid_q;
  assign o_resp_data = resp_q;
  assign o_fault = fault_q;
  assign o_enable_fault_latch = en_latch_q;
  assign o_channel_control_mode = cmode_q;
  assign o_diag_prediv = prediv_q;
  assign o_auto_zero_off = az_off_q;
  assign o_short_battery_threshold = thr_q;

endmodule : fmd_config_regs

`default_nettype wire

// ==== dv/fmd_config_regs_assertions.sv ====
// Checker for message answers, word decode and enable pin latch
`timescale 1ns/1ps
`default_nettype none

module fmd_config_regs_chk
  import fmd_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_msg_valid,
  input wire logic [MSG_W-1:0] i_msg_data,
  input wire logic i_enable_pin,
  input wire logic o_resp_valid,
  input wire logic [MSG_W-1:0] o_resp_data,
  input wire logic o_fault,
  input wire logic o_enable_fault_latch,
  input wire logic [NUM_CH-1:0] o_channel_control_mode,
  input wire logic [PREDIV_W-1:0] o_diag_prediv,
  input wire logic o_auto_zero_off,
  input wire logic [2*NUM_CH-1:0] o_short_battery_threshold
);
  // ==========================================================================
  // Fields of the answer, reordered to output layout
  // ==========================================================================
  logic [4:0] rid; // Identifier echoed in the answer
  logic [3:0] rmode; // Mode bits, channel 0 at bit 0
  logic [7:0] rthr; // Threshold codes, channel 0 at bits 1:0
  logic [8:0] rdiv; // Divider the answered timer code asks for
  assign rid = o_resp_data[30:26];
  assign rmode = {o_resp_data[20], o_resp_data[21], o_resp_data[22], o_resp_data[23]};
  assign rthr = {o_resp_data[5:4], o_resp_data[11:10], o_resp_data[17:16], o_resp_data[23:22]};
  assign rdiv = (o_resp_data[13:12] == 2'h0) ? 9'h080 :
                (o_resp_data[13:12] == 2'h3) ? 9'h100 : 9'h0c0;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  // ==========================================================================
  // Assertions
  // ==========================================================================
  resp_timing_a:
    assert property (1 |=> o_resp_valid == $past(i_msg_valid &&
      (i_msg_data[30:26] == ID_MODE_MASK || i_msg_data[30:26] == ID_DIAG_CFG)))
    else $error("answer pulse does not match a configuration message");
  id_echo_a:
    assert property (o_resp_valid |-> rid == $past(i_msg_data[30:26]))
    else $error("answer identifier differs from the message");
  unused_zero_a:
    assert property (o_resp_valid |-> !o_resp_data[31] && o_resp_data[25:24] == 2'h0 &&
      (rid != ID_MODE_MASK || o_resp_data[10:0] == 11'h0))
    else $error("answer top or unused bits not zero");
  mode_out_a:
    assert property (o_resp_valid && rid == ID_MODE_MASK |=>
      o_channel_control_mode == $past(rmode))
    else $error("control mode outputs differ from stored word");
  prediv_map_a:
    assert property (o_resp_valid && rid == ID_MODE_MASK |=> o_diag_prediv == $past(rdiv))
    else $error("pre-divider differs from timer code");
  auto_zero_a:
    assert property (o_resp_valid && rid == ID_MODE_MASK |=>
      o_auto_zero_off == $past(o_resp_data[11]))
    else $error("auto-zero output differs from stored bit");
  thresh_map_a:
    assert property (o_resp_valid && rid == ID_DIAG_CFG |=>
      o_short_battery_threshold == $past(rthr))
    else $error("threshold outputs differ from stored word");
  reset_state_a:
    assert property (disable iff (1'b0) !i_rst_b |=> !o_resp_valid && !o_fault &&
      o_diag_prediv == 9'h080 && o_short_battery_threshold == 8'hff &&
      o_channel_control_mode == 4'h0)
    else $error("outputs not at reset values");
  enable_latch_a:
    assert property ($fell(i_enable_pin) |-> ##[1:4] o_enable_fault_latch)
    else $error("enable pin fall not latched");
  latch_clear_a:
    assert property ($fell(o_enable_fault_latch) |->
      $past(i_msg_valid && i_msg_data[30:26] == ID_DIAG_READ))
    else $error("enable latch cleared without a diagnostic read");

  // Main scenarios reached
  mode_write_c: cover property (o_resp_valid && rid == ID_MODE_MASK);
  diag_write_c: cover property (o_resp_valid && rid == ID_DIAG_CFG);
  latch_clear_c: cover property ($fell(o_enable_fault_latch));
endmodule : fmd_config_regs_chk

bind fmd_config_regs fmd_config_regs_chk fmd_config_regs_chk_inst (.i_sys_clk, .i_rst_b,
  .i_msg_valid, .i_msg_data, .i_enable_pin, .o_resp_valid, .o_resp_data, .o_fault,
  .o_enable_fault_latch, .o_channel_control_mode, .o_diag_prediv, .o_auto_zero_off,
  .o_short_battery_threshold);

`default_nettype wire

// ==== dv/fmd_host_model.sv ====
// Host controller model that sends message words and takes the answers
`timescale 1ns/1ps
`default_nettype none

module fmd_host_model
  import fmd_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_resp_valid,
  input wire logic [MSG_W-1:0] i_resp_data,
  output logic o_msg_valid,
  output logic [MSG_W-1:0] o_msg_data
);
  // Idle bus at time zero
  initial begin
    o_msg_valid = 1'b0;
    o_msg_data = '0;
  end

  // ==========================================================================
  // One message: a single valid cycle, answer taken the cycle after
  // ==========================================================================
  task automatic xfer(input logic [MSG_W-1:0] w, output logic got, output logic [MSG_W-1:0] rsp);
    @(posedge i_sys_clk);
    #1;
    // access bit and identifier carried in word
    o_msg_valid = 1'b1;
    o_msg_data = w;
    @(posedge i_sys_clk);
    #1;
    o_msg_valid = 1'b0;
    // Released line shows the inverse, so a stale word is never reused
    o_msg_data = ~w;
    got = i_resp_valid;
    rsp = i_resp_data;
  endtask : xfer
endmodule : fmd_host_model

`default_nettype wire

// ==== dv/fmd_config_regs_bench.sv ====
// Self-checking bench for the configuration words and fault paths
`timescale 1ns/1ps
`default_nettype none

module fmd_config_regs_bench
  import fmd_pkg::*;
;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic clk, rst_b, msg_valid, en_pin, reset_b_pin, pwm_tick, resp_valid, fault, latch, azoff;
  logic [31:0] msg_data, resp_data, rsp;
  logic [3:0] chan_fault, short_fault, mode, retry, waiting;
  logic [8:0] prediv;
  logic [7:0] thr;
  logic got; // Answer seen for last message
  int mismatches = 0;
  int check_count = 0;
  logic [8:0] pdv [4] = '{9'h080, 9'h0c0, 9'h0c0, 9'h100}; // Divider per timer code
  int bad_ids [4] = '{0, 6, 9, 31}; // Identifiers that get no answer

  fmd_config_regs fmd_config_regs_inst (.i_sys_clk(clk), .i_rst_b(rst_b),
    .i_msg_valid(msg_valid), .i_msg_data(msg_data), .i_enable_pin(en_pin),
    .i_reset_b_pin(reset_b_pin), .i_chan_fault(chan_fault),
    .i_short_battery_fault(short_fault), .i_pwm_tick(pwm_tick),
    .o_resp_valid(resp_valid), .o_resp_data(resp_data),
    .o_fault(fault), .o_enable_fault_latch(latch), .o_channel_control_mode(mode),
    .o_diag_prediv(prediv), .o_auto_zero_off(azoff), .o_short_battery_threshold(thr),
    .o_short_battery_retry(retry), .o_short_battery_waiting(waiting));
  fmd_host_model fmd_host_model_inst (.i_sys_clk(clk), .i_resp_valid(resp_valid),
    .i_resp_data(resp_data), .o_msg_valid(msg_valid), .o_msg_data(msg_data));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [31:0] msg(input logic wr, input logic [4:0] id, input logic [25:0] f);
    return {wr, id, f};
  endfunction : msg

  task automatic chk(input string what, input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Let n edges pass, then settle past the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic send(input logic [31:0] w);
    fmd_host_model_inst.xfer(w, got, rsp);
  endtask : send

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  // Start a retry wait and count PWM ticks until the retry pulse
  task automatic retry_run(input int ch, input int exp);
    int ticks;
    ticks = 0;
    short_fault[ch] = 1'b1;
    step(1);
    short_fault[ch] = 1'b0;
    step(1);
    chk("waiting", waiting[ch], 1'b1);
    for (int i = 0; i < 200 && retry[ch] !== 1'b1; i++) begin
      pwm_tick = (i % 4 == 3);
      ticks += pwm_tick;
      step(1);
    end
    pwm_tick = 1'b0;
    // A wait that never ends closes the run
    if (retry[ch] !== 1'b1) begin
      $display("mismatch retry pulse expected 1 seen 0");
      mismatches++;
      finish_test();
    end else begin
      chk("retry ticks", ticks, exp);
    end
  endtask : retry_run

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ==========================================================================
  // Test sequence
  // ==========================================================================
  initial begin
    rst_b = 1'b0;
    en_pin = 1'b1;
    reset_b_pin = 1'b1;
    chan_fault = 4'h0;
    short_fault = 4'h0;
    pwm_tick = 1'b0;
    repeat (16) @(posedge clk);
    #1;
    rst_b = 1'b1;
    send(msg(0, ID_MODE_MASK, 0));
    chk("mode word", {got, rsp}, 33'h1_1c00_0000);
    send(msg(0, ID_DIAG_CFG, 0));
    chk("diag word", {got, rsp}, 33'h1_20ff_ffff);
    chk("outputs", {prediv, thr, mode, azoff, fault, latch}, {9'h080, 8'hff, 7'h0});
    $display("reset values done");
    send(msg(1, ID_MODE_MASK, 26'h3ffffff));
    chk("mode all", {got, rsp}, 33'h1_1cff_f800);
    step(1);
    chk("mode outs", {mode, azoff, prediv}, {4'hf, 1'b1, 9'h100});
    for (int c = 0; c < 4; c++) begin
      send(msg(1, ID_MODE_MASK, 26'h800000 | 26'(c << 12)));
      step(1);
      chk("prediv", {mode, azoff, prediv}, {4'h1, 1'b0, pdv[c]});
    end
    send(msg(0, ID_MODE_MASK, 26'h3ffffff));
    chk("read only", {got, rsp}, 33'h1_1c80_3000);
    send(msg(1, ID_DIAG_CFG, 26'h305097a));
    chk("diag write", {got, rsp}, 33'h1_2005_097a);
    step(1);
    chk("thresholds", thr, 8'he4);
    send(msg(0, ID_DIAG_CFG, 0));
    chk("diag read", {got, rsp}, 33'h1_2005_097a);
    foreach (bad_ids[k]) begin
      send(msg(1, 5'(bad_ids[k]), 0));
      chk("no answer", got, 1'b0);
    end
    $display("word access done");
    chan_fault = 4'hf;
    step(4);
    chk("masked", fault, 1'b0);
    send(msg(1, ID_MODE_MASK, 26'h080000));
    step(3);
    chk("ch0 fault", fault, 1'b1);
    chan_fault = 4'he;
    step(3);
    chk("others masked", fault, 1'b0);
    chan_fault = 4'h0;
    send(msg(1, ID_MODE_MASK, 26'h008000));
    en_pin = 1'b0;
    step(5);
    chk("enable low", {latch, fault}, 2'b11);
    send(msg(0, ID_DIAG_READ, 0));
    chk("read while low", latch, 1'b1);
    en_pin = 1'b1;
    step(5);
    chk("latch held", {latch, fault}, 2'b11);
    send(msg(0, ID_DIAG_READ, 0));
    step(3);
    chk("latch cleared", {latch, fault}, 2'b00);
    send(msg(1, ID_MODE_MASK, 0));
    en_pin = 1'b0;
    step(5);
    chk("enable gated", fault, 1'b0);
    en_pin = 1'b1;
    step(4);
    send(msg(0, ID_DIAG_READ, 0));
    send(msg(1, ID_MODE_MASK, 26'h004000));
    reset_b_pin = 1'b0;
    step(5);
    chk("reset pin low", fault, 1'b1);
    send(msg(1, ID_MODE_MASK, 0));
    step(3);
    chk("reset pin gated", fault, 1'b0);
    reset_b_pin = 1'b1;
    $display("fault paths done");
    retry_run(0, 4);
    retry_run(1, 1);
    $display("retry waits done");
    finish_test();
  end
endmodule : fmd_config_regs_bench

`default_nettype wire
